// ---- hw/auto_zero_sequencer.sv ----
// Host controller that auto-zeroes a preamp ahead of an 8-bit converter
// How it works
// RULE1: Converter reads all zero when the differential input is not positive.
// RULE2: Data read is inverted; trim and switch outputs are driven inverted.
// RULE3: A zero result clears the trim bit at the trial pointer.
// RULE4: A nonzero result sets the trim bit at the trial pointer.
// RULE5: Zeroing takes exactly eight trial-and-decide steps.
// RULE6: Short switch closed while zeroing, then signal switch closed instead.
// RULE7: Two switch bits of one port always hold opposite states.
// RULE8: Trim code is held on its own 8-bit output port.
// RULE9: Port device is set to mode 0, data in, trim and switches out.
// RULE10: Port map: data E4, trim E5, switches E6, control word E7.
// RULE11: Done interrupt leads into the result step: read, invert, then decide.
// RULE12: Zeroing starts with pointer 80 and trim 7F, outputs trim, converts.
// RULE13: Pointer shifts right after each decision; at zero switches swap.
// RULE14: Every trim update is followed by a new start and a done wait; the code starts no conversion after the eighth.
`timescale 1ns/100ps
`default_nettype none
`include "auto_zero_defs.svh"
module auto_zero_sequencer #(
  parameter int START_CYC = `START_PULSE_CYC
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  // AXI4-Lite slave
  input wire logic [4:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [4:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Converter side; data, trim and switch pins through inverting buffers
  input wire logic [7:0] conv_data_n,
  input wire logic conversion_done_interrupt_n,
  output logic conv_start_n,
  output logic [7:0] trim_port_n,
  output logic [1:0] switch_port_n,
  output logic [7:0] port_cfg_word,
  output logic [7:0] port_cfg_addr,
  output logic irq
);
  import auto_zero_pkg::*;

  seq_state_t state_ff;
  seq_state_t nxt_state;
  byte_t trim_ff;
  byte_t ptr_ff;
  byte_t data_ff;
  byte_t result;
  logic [1:0] sw_ff;
  logic zeroing_ff;
  logic zeroed_ff;
  logic [3:0] step_ff;
  logic [7:0] pulse_ff;
  logic [1:0] irq_stat_ff;
  logic [1:0] irq_en_ff;
  logic [1:0] irq_set;
  logic [1:0] irq_clr;
  logic [7:0] data_sync;
  logic done_n_sync;
  logic cmd_zero;
  logic cmd_conv;
  logic aw_hold_ff;
  logic w_hold_ff;
  logic [4:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic wr_go;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic zero_last;

  // Pins from the converter cross into this clock
  pin_sync #(.WIDTH(9), .INIT(9'h1FF)) u_sync (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .pin_in({conversion_done_interrupt_n, conv_data_n}),
    .pin_out({done_n_sync, data_sync})
  );

  // RULE2 read inversion
  // RULE1 all-zero means non-positive input
  assign result = ~data_sync;

  // AXI4-Lite write path, each ready drops while its half is held
  assign s_axi_awready = ~aw_hold_ff;
  assign s_axi_wready = ~w_hold_ff;
  assign wr_go = aw_hold_ff & w_hold_ff & ~bvalid_ff;

  // Address and data latched in either order
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      aw_hold_ff <= 1'b0;
      w_hold_ff <= 1'b0;
      awaddr_ff <= 5'h00;
      wdata_ff <= 32'h00000000;
      wstrb_ff <= 4'h0;
    end else begin
      if (s_axi_awvalid & ~aw_hold_ff) begin
        aw_hold_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_hold_ff <= 1'b0;
      end
      if (s_axi_wvalid & ~w_hold_ff) begin
        w_hold_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end else if (wr_go) begin
        w_hold_ff <= 1'b0;
      end
    end
  end

  // Write response, error for an unmapped or read-only offset
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= `RESP_OKAY;
    end else if (wr_go) begin
      bvalid_ff <= 1'b1;
      case (awaddr_ff)
        `REG_CTRL, `REG_IRQ_CLR, `REG_IRQ_EN: bresp_ff <= `RESP_OKAY;
        default: bresp_ff <= `RESP_SLVERR;
      endcase
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;

  // Commands are pulses; ignored while a sequence runs
  assign cmd_zero = wr_go & (awaddr_ff == `REG_CTRL) & wstrb_ff[0]
    & wdata_ff[`CTRL_ZERO_BIT] & (state_ff == ST_IDLE);
  assign cmd_conv = wr_go & (awaddr_ff == `REG_CTRL) & wstrb_ff[0]
    & wdata_ff[`CTRL_CONV_BIT] & ~wdata_ff[`CTRL_ZERO_BIT]
    & (state_ff == ST_IDLE);
  assign irq_clr = (wr_go & (awaddr_ff == `REG_IRQ_CLR) & wstrb_ff[0])
    ? wdata_ff[1:0] : 2'h0;

  // Interrupt enable register
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_en_ff <= 2'h0;
    end else if (wr_go & (awaddr_ff == `REG_IRQ_EN) & wstrb_ff[0]) begin
      irq_en_ff <= wdata_ff[1:0];
    end
  end

  // AXI4-Lite read path, one read in flight
  assign s_axi_arready = ~rvalid_ff;

  // One cycle from address to data
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      rresp_ff <= `RESP_OKAY;
    end else if (s_axi_arvalid & ~rvalid_ff) begin
      rvalid_ff <= 1'b1;
      rresp_ff <= `RESP_OKAY;
      case (s_axi_araddr)
        `REG_CTRL: rdata_ff <= 32'h00000000;
        `REG_STATUS: rdata_ff <= {22'h000000, step_ff, sw_ff,
          zeroed_ff, zeroing_ff, 1'b0, (state_ff != ST_IDLE)};
        `REG_TRIM: rdata_ff <= {24'h000000, trim_ff};
        `REG_DATA: rdata_ff <= {24'h000000, data_ff};
        `REG_IRQ_STAT: rdata_ff <= {30'h00000000, irq_stat_ff};
        `REG_IRQ_CLR: rdata_ff <= 32'h00000000;
        `REG_IRQ_EN: rdata_ff <= {30'h00000000, irq_en_ff};
        default: begin
          rdata_ff <= 32'h00000000;
          rresp_ff <= `RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  // RULE5 eighth step ends search
  assign zero_last = (ptr_ff >> 1) == 8'h00;

  // Next state
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: nxt_state = (cmd_zero | cmd_conv) ? ST_START : ST_IDLE;
      ST_START: nxt_state = (pulse_ff == 8'(START_CYC - 1)) ? ST_ARM : ST_START;
      // Wait for done to drop away so a stale level is not taken
      ST_ARM: nxt_state = done_n_sync ? ST_WAIT : ST_ARM;
      ST_WAIT: nxt_state = done_n_sync ? ST_WAIT : ST_RESULT;
      ST_RESULT: nxt_state = (zeroing_ff & ~zero_last) ? ST_START : ST_IDLE;
      default: nxt_state = ST_IDLE;
    endcase
  end

  // RULE14 restart after every update but the eighth
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Start pulse width counter
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pulse_ff <= 8'h00;
      conv_start_n <= 1'b1;
    end else begin
      conv_start_n <= ~(nxt_state == ST_START);
      if (state_ff == ST_START) begin
        pulse_ff <= pulse_ff + 8'h01;
      end else begin
        pulse_ff <= 8'h00;
      end
    end
  end

  // RULE12 initial pointer and code
  // RULE3 RULE4 trial bit decision
  // RULE13 pointer shift
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ptr_ff <= 8'h00;
      trim_ff <= `TRIM_INIT;
      step_ff <= 4'h0;
    end else if (cmd_zero) begin
      ptr_ff <= `PTR_INIT;
      trim_ff <= `TRIM_INIT;
      step_ff <= 4'h0;
    end else if ((state_ff == ST_RESULT) & zeroing_ff) begin
      // RULE11 result step drives the decision
      if (result == 8'h00) begin
        trim_ff <= trim_ff & ~ptr_ff;
      end else begin
        trim_ff <= trim_ff | ptr_ff;
      end
      ptr_ff <= ptr_ff >> 1;
      step_ff <= step_ff + 4'h1;
    end
  end

  // RULE6 switch sequencing
  // RULE7 switches kept opposite
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sw_ff <= `SW_SIGNAL;
      zeroing_ff <= 1'b0;
      zeroed_ff <= 1'b0;
    end else if (cmd_zero) begin
      sw_ff <= `SW_ZEROING;
      zeroing_ff <= 1'b1;
      zeroed_ff <= 1'b0;
    end else if ((state_ff == ST_RESULT) & zeroing_ff & zero_last) begin
      sw_ff <= `SW_SIGNAL;
      zeroing_ff <= 1'b0;
      zeroed_ff <= 1'b1;
    end
  end

  // Normal conversion result, kept for software
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      data_ff <= 8'h00;
    end else if ((state_ff == ST_RESULT) & ~zeroing_ff) begin
      data_ff <= result;
    end
  end

  // RULE8 trim port held
  // RULE2 outputs driven inverted through the buffers
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      trim_port_n <= ~`TRIM_INIT;
      switch_port_n <= ~`SW_SIGNAL;
    end else begin
      trim_port_n <= ~trim_ff;
      switch_port_n <= ~sw_ff;
    end
  end

  // RULE9 mode 0 control word
  // RULE10 control word port address
  assign port_cfg_word = `PORT_CFG_MODE0;
  assign port_cfg_addr = `PORT_CTRL_ADDR;

  // Sticky events; a set in the clear cycle wins
  assign irq_set[`IRQ_ZERO_BIT] = (state_ff == ST_RESULT) & zeroing_ff & zero_last;
  assign irq_set[`IRQ_CONV_BIT] = (state_ff == ST_RESULT) & ~zeroing_ff;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_stat_ff <= 2'h0;
    end else begin
      irq_stat_ff <= (irq_stat_ff & ~irq_clr) | irq_set;
    end
  end

  assign irq = |(irq_stat_ff & irq_en_ff);

  // Checks on the sequence and the pins
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  a_switch_opposite: assert property (switch_port_n[0] != switch_port_n[1]) // RULE7
    else $error("switch bits not opposite");
  a_pins_inverted: assert property (##1 trim_port_n == ~$past(trim_ff)) // RULE2
    else $error("trim port not inverted trim code");
  a_zero_clears: assert property (
    (state_ff == ST_RESULT) && zeroing_ff && (result == 8'h00)
    |=> (trim_ff & $past(ptr_ff)) == 8'h00) // RULE3
    else $error("zero result did not clear trial bit");
  a_nonzero_sets: assert property (
    (state_ff == ST_RESULT) && zeroing_ff && (result != 8'h00)
    |=> (trim_ff & $past(ptr_ff)) == $past(ptr_ff)) // RULE4
    else $error("nonzero result did not set trial bit");
  a_eight_steps: assert property (
    $rose(zeroed_ff) |-> step_ff == `ZERO_STEPS) // RULE5
    else $error("zeroing did not take eight steps");
  a_init_code: assert property (
    cmd_zero |=> ptr_ff == `PTR_INIT && trim_ff == `TRIM_INIT
    && sw_ff == `SW_ZEROING ##1 !conv_start_n) // RULE12
    else $error("zeroing start values wrong");
  a_ptr_shift: assert property (
    (state_ff == ST_RESULT) && zeroing_ff |=> ptr_ff == ($past(ptr_ff) >> 1)) // RULE13
    else $error("pointer not shifted");
  a_swap_done: assert property (
    (state_ff == ST_RESULT) && zeroing_ff && zero_last
    |=> sw_ff == `SW_SIGNAL ##1 switch_port_n == ~`SW_SIGNAL) // RULE6
    else $error("switches not swapped at end");
  a_restart_conv: assert property (
    (state_ff == ST_RESULT) && zeroing_ff && !zero_last
    |=> state_ff == ST_START && !conv_start_n) // RULE14
    else $error("no new start after trim update");
  a_result_entry: assert property (
    (state_ff == ST_WAIT) && !done_n_sync |=> state_ff == ST_RESULT) // RULE11
    else $error("done not taken into result step");
  a_mode_word: assert property (port_cfg_word == `PORT_CFG_MODE0) // RULE9
    else $error("port device mode word wrong");
endmodule // auto_zero_sequencer
`default_nettype wire

// ---- hw/auto_zero_defs.svh ----
// Register offsets, field positions, reset values and timing counts
`ifndef AUTO_ZERO_DEFS_SVH
`define AUTO_ZERO_DEFS_SVH
`define REG_CTRL 5'h00
`define REG_STATUS 5'h04
`define REG_TRIM 5'h08
`define REG_DATA 5'h0C
`define REG_IRQ_STAT 5'h10
`define REG_IRQ_CLR 5'h14
`define REG_IRQ_EN 5'h18
`define CTRL_ZERO_BIT 0
`define CTRL_CONV_BIT 1
`define IRQ_ZERO_BIT 0
`define IRQ_CONV_BIT 1
`define PORT_DATA_ADDR 8'hE4
`define PORT_TRIM_ADDR 8'hE5
`define PORT_SWITCH_ADDR 8'hE6
`define PORT_CTRL_ADDR 8'hE7
`define PORT_CFG_MODE0 8'h90
`define PTR_INIT 8'h80
`define TRIM_INIT 8'h7F
`define ZERO_STEPS 4'h8
`define SW_SHORT_BIT 0
`define SW_PATH_BIT 1
`define SW_ZEROING 2'h1
`define SW_SIGNAL 2'h2
`define CLK_MHZ 40
`define START_PULSE_NS 100
`define START_PULSE_CYC (((`START_PULSE_NS * `CLK_MHZ) + 999) / 1000)
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ---- hw/auto_zero_pkg.sv ----
// Types shared by the auto-zero sequencer
package auto_zero_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_START,
    ST_ARM,
    ST_WAIT,
    ST_RESULT
  } seq_state_t;
  typedef logic [7:0] byte_t;
endpackage

// ---- hw/pin_sync.sv ----
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_out
);
  logic [WIDTH-1:0] s1_ff;
  logic [WIDTH-1:0] s2_ff;
  logic [WIDTH-1:0] s3_ff;
  logic [WIDTH-1:0] out_ff;

  // Stage one feeds stage two only
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s1_ff <= INIT;
      s2_ff <= INIT;
      s3_ff <= INIT;
    end else begin
      s1_ff <= pin_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // Each bit changes only once stages two and three agree
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
          out_ff[i] <= INIT[i];
        end else if (s2_ff[i] == s3_ff[i]) begin
          out_ff[i] <= s3_ff[i];
        end
      end
    end
  endgenerate

  assign pin_out = out_ff;
endmodule // pin_sync
`default_nettype wire

// ---- sim/conv_model.sv ----
// Converter, preamp switches and trim DAC seen from the sequencer pins
`timescale 1ns/100ps
`default_nettype none
module conv_model #(
  parameter int CONV_CYC = 20,
  parameter logic [7:0] SIG_CODE = 8'h5A
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [7:0] preamp_offset,
  input wire logic conv_start_n,
  input wire logic [7:0] trim_port_n,
  input wire logic [1:0] switch_port_n,
  output logic [7:0] conv_data_n,
  output logic conversion_done_interrupt_n
);
  logic start_q;
  int cnt;
  int n_conv;
  logic [7:0] trim_log [0:31];
  logic [7:0] res_log [0:31];
  logic [7:0] trim_v;
  logic [7:0] res_v;
  assign trim_v = ~trim_port_n;
  always_comb begin
    if (!switch_port_n[0]) begin
      res_v = (preamp_offset > trim_v) ? preamp_offset - trim_v : 8'h00;
    end else begin
      res_v = SIG_CODE;
    end
  end
  // Start edge drops done; result lands after conversion time
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      start_q <= 1'b1;
      cnt <= 0;
      n_conv <= 0;
      conv_data_n <= 8'hFF;
      conversion_done_interrupt_n <= 1'b1;
    end else begin
      start_q <= conv_start_n;
      if (start_q && !conv_start_n) begin
        cnt <= CONV_CYC;
        conversion_done_interrupt_n <= 1'b1;
      end else if (cnt == 1) begin
        cnt <= 0;
        conv_data_n <= ~res_v;
        conversion_done_interrupt_n <= 1'b0;
        trim_log[n_conv] <= trim_v;
        res_log[n_conv] <= res_v;
        n_conv <= n_conv + 1;
      end else if (cnt > 1) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule // conv_model
`default_nettype wire

// ---- sim/tb_top.sv ----
// Bench for the auto-zero sequencer driven over AXI4-Lite
`timescale 1ns/100ps
`default_nettype none
`include "auto_zero_defs.svh"
module tb_top;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [4:0] s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, switch_port_n;
  logic conv_start_n, done_n, irq;
  logic [7:0] conv_data_n, trim_port_n, cfg_word, cfg_addr;
  logic [7:0] offset = 8'h00;
  int miscompares = 0;
  int n_checks = 0;
  auto_zero_sequencer auto_zero_sequencer_inst (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .conv_data_n(conv_data_n),
    .conversion_done_interrupt_n(done_n), .conv_start_n(conv_start_n),
    .trim_port_n(trim_port_n), .switch_port_n(switch_port_n), .port_cfg_word(cfg_word),
    .port_cfg_addr(cfg_addr), .irq(irq));
  conv_model conv_model_inst (.sys_clk(sys_clk), .sys_rst(sys_rst), .preamp_offset(offset),
    .conv_start_n(conv_start_n), .trim_port_n(trim_port_n), .switch_port_n(switch_port_n),
    .conv_data_n(conv_data_n), .conversion_done_interrupt_n(done_n));
  // Clock at 40 MHz
  always #12.5 sys_clk = ~sys_clk;
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic print_verdict();
    if (miscompares == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Sampling at the falling edge sees what the next rising edge takes
  task automatic axi_write(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ah, wh, bh, hb;
    logic [1:0] r;
    hb = 1'b0;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!hb) begin
      @(negedge sys_clk);
      ah = s_axi_awvalid && s_axi_awready;
      wh = s_axi_wvalid && s_axi_wready;
      bh = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge sys_clk);
      if (ah) s_axi_awvalid <= 1'b0;
      if (wh) s_axi_wvalid <= 1'b0;
      if (bh) s_axi_bready <= 1'b0;
      hb = bh;
    end
    chk("bresp", {30'h0, er}, {30'h0, r});
  endtask
  task automatic axi_read(input logic [4:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ah, rh;
    logic [31:0] d;
    logic [1:0] r;
    rh = 1'b0;
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!rh) begin
      @(negedge sys_clk);
      ah = s_axi_arvalid && s_axi_arready;
      rh = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge sys_clk);
      if (ah) s_axi_arvalid <= 1'b0;
      if (rh) s_axi_rready <= 1'b0;
    end
    chk("rdata", ed, d);
    chk("rresp", {30'h0, er}, {30'h0, r});
  endtask
  task automatic wait_irq();
    for (int i = 0; i < 3000 && irq !== 1'b1; i++) @(negedge sys_clk);
    chk("irq_rise", 32'h1, {31'h0, irq});
  endtask
  // One zeroing pass; each decision is judged against the result that drove it
  task automatic run_zero(input logic [7:0] off);
    int b;
    logic [7:0] p, t, hi, fin;
    offset <= off;
    b = conv_model_inst.n_conv;
    axi_write(`REG_CTRL, 32'h1, `RESP_OKAY);
    @(negedge sys_clk);
    chk("sw_zeroing", 32'h2, {30'h0, switch_port_n});
    wait_irq();
    // Switch and trim pins follow the final decision one edge later
    @(negedge sys_clk);
    chk("steps", 32'h8, 32'(conv_model_inst.n_conv - b));
    chk("sw_signal", 32'h1, {30'h0, switch_port_n});
    chk("first_code", 32'h7F, {24'h0, conv_model_inst.trim_log[b]});
    fin = conv_model_inst.trim_log[b + 7] & 8'hFE;
    fin = fin | {7'h0, conv_model_inst.res_log[b + 7] != 8'h00};
    for (int k = 0; k < 8; k++) begin
      p = 8'h80 >> k;
      hi = ~((p << 1) - 8'h01);
      t = (k < 7) ? conv_model_inst.trim_log[b + k + 1] : fin;
      chk("trim_bit", {31'h0, conv_model_inst.res_log[b + k] != 8'h00},
        {31'h0, (t & p) != 8'h00});
      chk("trim_upper", {24'h0, conv_model_inst.trim_log[b + k] & hi}, {24'h0, t & hi});
    end
    chk("trim_port", {24'h0, ~fin}, {24'h0, trim_port_n});
    axi_read(`REG_TRIM, {24'h0, fin}, `RESP_OKAY);
    axi_read(`REG_STATUS, {22'h0, `ZERO_STEPS, `SW_SIGNAL, 4'h8}, `RESP_OKAY);
    axi_read(`REG_IRQ_STAT, 32'h1, `RESP_OKAY);
    axi_write(`REG_IRQ_CLR, 32'h1, `RESP_OKAY);
    @(negedge sys_clk);
    chk("irq_clear", 32'h0, {31'h0, irq});
  endtask
  // Switch pair must never agree
  always @(negedge sys_clk) begin
    if (!sys_rst) chk("sw_opposite", 32'h1, {31'h0, switch_port_n[0] ^ switch_port_n[1]});
  end
  // Watchdog well past the expected run length
  initial begin
    repeat (20000) @(posedge sys_clk);
    miscompares++;
    print_verdict();
  end
  // Main sequence
  initial begin
    repeat (3) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(negedge sys_clk);
    chk("cfg_word", 32'h90, {24'h0, cfg_word});
    chk("cfg_addr", 32'hE7, {24'h0, cfg_addr});
    chk("trim_reset", 32'h80, {24'h0, trim_port_n});
    chk("irq_reset", 32'h0, {31'h0, irq});
    axi_read(`REG_CTRL, 32'h0, `RESP_OKAY);
    axi_read(5'h1C, 32'h0, `RESP_SLVERR);
    axi_write(`REG_STATUS, 32'h1, `RESP_SLVERR);
    axi_write(`REG_IRQ_EN, 32'h1, `RESP_OKAY);
    run_zero(8'h9C);
    run_zero(8'h03);
    axi_write(`REG_IRQ_EN, 32'h2, `RESP_OKAY);
    axi_write(`REG_CTRL, 32'h2, `RESP_OKAY);
    wait_irq();
    axi_read(`REG_DATA, 32'h5A, `RESP_OKAY);
    axi_write(`REG_IRQ_EN, 32'h0, `RESP_OKAY);
    @(negedge sys_clk);
    chk("irq_mask", 32'h0, {31'h0, irq});
    axi_read(`REG_IRQ_STAT, 32'h2, `RESP_OKAY);
    axi_write(`REG_IRQ_CLR, 32'h2, `RESP_OKAY);
    axi_read(`REG_IRQ_STAT, 32'h0, `RESP_OKAY);
    print_verdict();
  end
endmodule // tb_top
`default_nettype wire
